// ---- rtl/nsc_map.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef NSC_MAP_SVH
`define NSC_MAP_SVH
`define NSC_OFS_PAGE_ADDR     8'h88
`define NSC_OFS_MEM_CTRL      8'h89
`define NSC_OFS_CHK_TRIGGER   8'h8a
`define NSC_OFS_ACTIVITY      8'h8b
`define NSC_OFS_CHK_RESULT    8'h8c
`define NSC_OFS_CHK_COMPUTED  8'h8d
`define NSC_OFS_CACHE_BASE    8'h40
`define NSC_BIT_PROGRAM       0
`define NSC_BIT_ERASE         1
`define NSC_BIT_ERASE_PROG    2
`define NSC_BIT_FIXED_TIME    3
`define NSC_BIT_READ_BUSY     0
`define NSC_BIT_ERASE_BUSY    1
`define NSC_BIT_PROG_BUSY     2
`define NSC_BIT_CALC          0
`define NSC_BIT_CHK_BUSY      0
`define NSC_BIT_CHK_MATCH     1
`define NSC_EXP_PAGE          4'hf
`define NSC_EXP_BYTE          3'h7
`define NSC_EXP_RESET         8'hb8
`define NSC_FIXED_TIME_US     8000
`define NSC_CLK_MHZ           20
`define NSC_FIXED_CYCLES      (`NSC_FIXED_TIME_US * `NSC_CLK_MHZ)
`define NSC_VAR_CYCLES        (`NSC_FIXED_CYCLES / 2)
`endif

// ---- rtl/nsc_pkg.sv ----
// Types shared by the status and checksum block
`default_nettype none
package nsc_pkg;
  typedef enum logic [1:0] {NSC_IDLE, NSC_ERASE, NSC_PROG} nsc_op_t;
  typedef enum logic [1:0] {NSC_CK_IDLE, NSC_CK_READ, NSC_CK_CMP}
    nsc_chk_t;
endpackage
`default_nettype wire

// ---- rtl/nsc_mem.sv ----
// Nonvolatile array model: 16 pages of 8 bytes with per-page erase/program
`default_nettype none
`include "nsc_map.svh"
module nsc_mem #(
  parameter int PAGES = 16,
  parameter int BYTES = 8
) (
  input  wire logic       clk,       // System clock
  input  wire logic       rst_n,     // Sync reset, active low
  input  wire logic       erase,     // Erase page pulse
  input  wire logic       prog,      // Program page pulse
  input  wire logic [3:0] page,      // Page selected
  input  wire logic [63:0] cache,    // Cache contents, byte 0 low
  input  wire logic [6:0] raddr,     // Read address page:byte
  output logic      [7:0] rdata      // Read data, registered
);
  initial begin
    if (PAGES != 16 || BYTES != 8) $error("nsc_mem: geometry fixed");
  end
  logic [7:0] mem [PAGES*BYTES];
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = mem[raddr];
  end
  always_ff @(posedge clk) begin
    rdata <= next_rdata;
    if (!rst_n) begin
      for (int i = 0; i < PAGES*BYTES; i++) begin
        mem[i] <= 8'hff;
      end
      mem[{`NSC_EXP_PAGE, `NSC_EXP_BYTE}] <= `NSC_EXP_RESET;
    end else begin
      for (int b = 0; b < BYTES; b++) begin
        if (erase) begin
          mem[{page, 3'(b)}] <= 8'hff;
        end else if (prog) begin
          mem[{page, 3'(b)}] <= cache[b*8 +: 8];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- rtl/nsc_sum.sv ----
// Eight-bit checksum accumulator
`default_nettype none
module nsc_sum (
  input  wire logic       clk,    // System clock
  input  wire logic       rst_n,  // Sync reset, active low
  input  wire logic       clear,  // Restart accumulation
  input  wire logic       add,    // Accumulate data this cycle
  input  wire logic [7:0] data,   // Byte to accumulate
  output logic      [7:0] sum     // Running checksum
);
  logic [7:0] next_sum;
  always_comb begin
    next_sum = sum;
    if (clear) begin
      next_sum = 8'h00;
    end else if (add) begin
      next_sum = {sum[6:0], 1'b0} ^ (sum[7] ? 8'h07 : 8'h00) ^ data;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sum <= 8'h00;
    end else begin
      sum <= next_sum;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/nsc_top.sv ----
// Nonvolatile memory status and checksum check with Avalon-MM slave
// Function
// - Status bit 2 high while programming
// - Status bit 1 high while erasing
// - Status bit 0 high while reading
// - Trigger bit 0 one starts checksum when no erase, program or check runs
// - Result bit 0 high while check runs
// - Result bit 1 shows expected equals computed
// - Computed checksum readable in bits 7:0
// - Expected checksum at page f byte 7
// - Control bits program, erase, erase-then-program
// - Fixed 8 ms timing else shorter
`default_nettype none
`include "nsc_map.svh"
module nsc_top #(
  parameter int FIXED_CYCLES = `NSC_FIXED_CYCLES,
  parameter int VAR_CYCLES   = `NSC_VAR_CYCLES
) (
  input  wire logic        clk,                // 20 MHz clock
  input  wire logic        rst_n,              // Sync reset, active low
  input  wire logic [7:0]  avs_address,        // Word index
  input  wire logic        avs_read,           // Read request
  input  wire logic        avs_write,          // Write request
  input  wire logic [31:0] avs_writedata,      // Write data
  output logic      [31:0] avs_readdata,       // Read data
  output logic             avs_waitrequest,    // Stall
  output logic      [1:0]  avs_response        // 00 ok, 10 slave error
);
  initial begin
    if (VAR_CYCLES < 1 || VAR_CYCLES >= FIXED_CYCLES)
      $error("nsc_top: VAR_CYCLES must be below FIXED_CYCLES");
  end

  // Bus answer: one wait cycle, then acknowledge
  logic        ack;
  logic        next_ack;
  logic        req;
  assign req = (avs_read || avs_write) && !ack;
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  always_comb begin
    next_ack = req;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= next_ack;
    end
  end
  logic wr_take;
  logic rd_take;
  assign wr_take = avs_write && ack;
  assign rd_take = avs_read && ack;

  // Control registers and page cache
  logic [3:0]  page;
  logic        fixed_cycle_time_sel;
  logic [63:0] cache;
  logic        trigger;
  logic [3:0]  next_page;
  logic        next_fixed;
  logic [63:0] next_cache;
  logic        next_trigger;
  logic        start_erase;
  logic        start_prog;
  logic        start_both;
  logic        start_chk;

  // Operation sequencer
  nsc_pkg::nsc_op_t op;
  nsc_pkg::nsc_op_t next_op;
  logic        then_prog;
  logic        next_then_prog;
  logic [23:0] tmr;
  logic [23:0] next_tmr;
  logic        mem_erase;
  logic        mem_prog;

  // Checksum walk
  nsc_pkg::nsc_chk_t ck;
  nsc_pkg::nsc_chk_t next_ck;
  logic [6:0]  ck_addr;
  logic [6:0]  next_ck_addr;
  logic        ck_valid;
  logic        next_ck_valid;
  logic        match;
  logic        next_match;
  logic [7:0]  expected;
  logic [7:0]  next_expected;
  logic [7:0]  rdata;
  logic [7:0]  sum;
  logic        sum_add;
  logic        idle;
  assign idle = (op == nsc_pkg::NSC_IDLE) && (ck == nsc_pkg::NSC_CK_IDLE);

  always_comb begin
    next_page    = page;
    next_fixed   = fixed_cycle_time_sel;
    next_cache   = cache;
    next_trigger = trigger;
    start_erase  = 1'b0;
    start_prog   = 1'b0;
    start_both   = 1'b0;
    start_chk    = 1'b0;
    if (ck == nsc_pkg::NSC_CK_CMP) begin
      next_trigger = 1'b0;
    end
    if (wr_take) begin
      if (avs_address == `NSC_OFS_PAGE_ADDR) begin
        next_page = avs_writedata[3:0];
      end else if (avs_address == `NSC_OFS_MEM_CTRL) begin
        next_fixed  = avs_writedata[`NSC_BIT_FIXED_TIME];
        start_prog  = avs_writedata[`NSC_BIT_PROGRAM] && idle;
        start_erase = avs_writedata[`NSC_BIT_ERASE] && idle;
        start_both  = avs_writedata[`NSC_BIT_ERASE_PROG] && idle;
      end else if (avs_address == `NSC_OFS_CHK_TRIGGER) begin
        // Upper bits ignored; zero is no action
        if (avs_writedata[`NSC_BIT_CALC] && idle) begin
          start_chk    = 1'b1;
          next_trigger = 1'b1;
        end
      end else if (avs_address[7:3] == 5'(`NSC_OFS_CACHE_BASE >> 3)) begin
        next_cache[avs_address[2:0]*8 +: 8] = avs_writedata[7:0];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      page                 <= 4'h0;
      fixed_cycle_time_sel <= 1'b0;
      cache                <= 64'hffffffffffffffff;
      trigger              <= 1'b0;
    end else begin
      page                 <= next_page;
      fixed_cycle_time_sel <= next_fixed;
      cache                <= next_cache;
      trigger              <= next_trigger;
    end
  end

  // Erase and program timing
  always_comb begin
    next_op        = op;
    next_then_prog = then_prog;
    next_tmr       = tmr;
    mem_erase      = 1'b0;
    mem_prog       = 1'b0;
    case (op)
      nsc_pkg::NSC_IDLE: begin
        // Timing bit written with the start applies to this op
        next_tmr = next_fixed ? 24'(FIXED_CYCLES - 1)
                              : 24'(VAR_CYCLES - 1);
        if (start_erase || start_both) begin
          next_op        = nsc_pkg::NSC_ERASE;
          next_then_prog = start_both;
        end else if (start_prog) begin
          next_op = nsc_pkg::NSC_PROG;
        end
      end
      nsc_pkg::NSC_ERASE: begin
        next_tmr = tmr - 24'h1;
        if (tmr == 24'h0) begin
          mem_erase = 1'b1;
          next_tmr  = fixed_cycle_time_sel ? 24'(FIXED_CYCLES - 1)
                                           : 24'(VAR_CYCLES - 1);
          next_op   = then_prog ? nsc_pkg::NSC_PROG : nsc_pkg::NSC_IDLE;
          next_then_prog = 1'b0;
        end
      end
      nsc_pkg::NSC_PROG: begin
        next_tmr = tmr - 24'h1;
        if (tmr == 24'h0) begin
          mem_prog = 1'b1;
          next_op  = nsc_pkg::NSC_IDLE;
        end
      end
      default: begin
        next_op = nsc_pkg::NSC_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op        <= nsc_pkg::NSC_IDLE;
      then_prog <= 1'b0;
      tmr       <= 24'h0;
    end else begin
      op        <= next_op;
      then_prog <= next_then_prog;
      tmr       <= next_tmr;
    end
  end

  // Checksum walk over all 127 bytes below the expected value
  always_comb begin
    next_ck       = ck;
    next_ck_addr  = ck_addr;
    next_ck_valid = 1'b0;
    next_match    = match;
    next_expected = expected;
    sum_add       = ck_valid && (ck == nsc_pkg::NSC_CK_READ);
    case (ck)
      nsc_pkg::NSC_CK_IDLE: begin
        next_ck_addr = 7'h0;
        if (start_chk) begin
          next_ck = nsc_pkg::NSC_CK_READ;
        end
      end
      nsc_pkg::NSC_CK_READ: begin
        // Read data lags the address by one cycle
        next_ck_addr  = ck_addr + 7'h1;
        next_ck_valid = 1'b1;
        if (ck_addr == {`NSC_EXP_PAGE, `NSC_EXP_BYTE}) begin
          next_ck       = nsc_pkg::NSC_CK_CMP;
          next_ck_valid = 1'b0;
        end
      end
      nsc_pkg::NSC_CK_CMP: begin
        // Read data now holds the stored expected byte
        next_expected = rdata;
        next_match    = (rdata == sum);
        next_ck       = nsc_pkg::NSC_CK_IDLE;
      end
      default: begin
        next_ck = nsc_pkg::NSC_CK_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ck       <= nsc_pkg::NSC_CK_IDLE;
      ck_addr  <= 7'h0;
      ck_valid <= 1'b0;
      match    <= 1'b0;
      expected <= 8'h00;
    end else begin
      ck       <= next_ck;
      ck_addr  <= next_ck_addr;
      ck_valid <= next_ck_valid;
      match    <= next_match;
      expected <= next_expected;
    end
  end

  nsc_mem u_mem (
    .clk     (clk),
    .rst_n   (rst_n),
    .erase   (mem_erase),
    .prog    (mem_prog),
    .page    (page),
    .cache   (cache),
    .raddr   (ck == nsc_pkg::NSC_CK_READ ? ck_addr : 7'h0),
    .rdata   (rdata)
  );
  nsc_sum u_sum (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (start_chk),
    .add   (sum_add),
    .data  (rdata),
    .sum   (sum)
  );

  // Status views and read mux
  logic [7:0] activity;
  logic [7:0] result;
  logic       chk_busy;
  assign chk_busy = (ck != nsc_pkg::NSC_CK_IDLE);
  always_comb begin
    activity = 8'h00;
    activity[`NSC_BIT_PROG_BUSY]  = (op == nsc_pkg::NSC_PROG);
    activity[`NSC_BIT_ERASE_BUSY] = (op == nsc_pkg::NSC_ERASE);
    activity[`NSC_BIT_READ_BUSY]  = (ck == nsc_pkg::NSC_CK_READ);
    result = 8'h00;
    result[`NSC_BIT_CHK_BUSY]  = chk_busy;
    result[`NSC_BIT_CHK_MATCH] = match;
  end
  logic [31:0] next_readdata;
  logic [1:0]  next_resp;
  always_comb begin
    next_readdata = 32'h0;
    next_resp     = 2'b00;
    if (avs_address == `NSC_OFS_PAGE_ADDR) begin
      next_readdata[3:0] = page;
    end else if (avs_address == `NSC_OFS_MEM_CTRL) begin
      next_readdata[`NSC_BIT_FIXED_TIME] = fixed_cycle_time_sel;
    end else if (avs_address == `NSC_OFS_CHK_TRIGGER) begin
      next_readdata[`NSC_BIT_CALC] = trigger;
    end else if (avs_address == `NSC_OFS_ACTIVITY) begin
      next_readdata[7:0] = activity;
    end else if (avs_address == `NSC_OFS_CHK_RESULT) begin
      next_readdata[7:0] = result;
    end else if (avs_address == `NSC_OFS_CHK_COMPUTED) begin
      next_readdata[7:0] = sum;
    end else if (avs_address[7:3] == 5'(`NSC_OFS_CACHE_BASE >> 3)) begin
      next_readdata[7:0] = cache[avs_address[2:0]*8 +: 8];
    end else begin
      next_resp = 2'b10;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0;
      avs_response <= 2'b00;
    end else if (req) begin
      avs_readdata <= next_readdata;
      avs_response <= next_resp;
    end
  end

  // Checks
  a_prog_flag: assert property (@(posedge clk) disable iff (!rst_n)
    mem_prog |=> !activity[`NSC_BIT_PROG_BUSY])
    else $error("program flag stuck");
  a_erase_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (op == nsc_pkg::NSC_ERASE) |-> activity[`NSC_BIT_ERASE_BUSY])
    else $error("erase flag low");
  a_read_flag: assert property (@(posedge clk) disable iff (!rst_n)
    start_chk |=> activity[`NSC_BIT_READ_BUSY])
    else $error("read flag low");
  a_trig_start: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_take && avs_address == `NSC_OFS_CHK_TRIGGER && idle &&
     avs_writedata[0]) |=> result[`NSC_BIT_CHK_BUSY])
    else $error("trigger did not start");
  a_busy_len: assert property (@(posedge clk) disable iff (!rst_n)
    start_chk |=> chk_busy [*8])
    else $error("busy dropped early");
  a_check_done: assert property (@(posedge clk) disable iff (!rst_n)
    start_chk |-> ##[129:130] !chk_busy)
    else $error("check too long");
  a_match_val: assert property (@(posedge clk) disable iff (!rst_n)
    (ck == nsc_pkg::NSC_CK_CMP) |=> (match == (expected == sum)))
    else $error("match wrong");
  a_sum_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !chk_busy && !start_chk |=> $stable(sum))
    else $error("sum moved");
  a_both_seq: assert property (@(posedge clk) disable iff (!rst_n)
    (mem_erase && then_prog) |=> (op == nsc_pkg::NSC_PROG))
    else $error("no program after erase");
endmodule
`default_nettype wire

// ---- tb/nsc_host.sv ----
// Host model that reaches the block over Avalon-MM
`default_nettype none
module nsc_host (
  input  wire logic        clk,             // System clock
  output logic      [7:0]  avs_address,     // Word index
  output logic             avs_read,        // Read request
  output logic             avs_write,       // Write request
  output logic      [31:0] avs_writedata,   // Write data
  input  wire logic [31:0] avs_readdata,    // Read data
  input  wire logic        avs_waitrequest, // Stall
  input  wire logic [1:0]  avs_response     // Response code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_data;
  logic [1:0] last_resp;
  initial begin
    avs_address   = 8'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h00000000;
  end
  // Request held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_writedata <= {24'h000000, d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    last_data = avs_readdata[7:0];
    last_resp = avs_response;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    avs_writedata <= ~avs_writedata;
    avs_address   <= ~a;
  endtask
endmodule
`default_nettype wire

// ---- tb/nvm_status_and_checksum_check_test.sv ----
// Self-checking bench for the status and checksum block
`default_nettype none
module nvm_status_and_checksum_check_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FIX = 20;
  localparam int VAR = 10;
  localparam int NR  = 11;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  adr;
  logic        rd_en;
  logic        wr_en;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        wreq;
  logic [1:0]  resp;
  logic [7:0]  q;
  logic [1:0]  rs;
  logic [7:0]  crc;
  logic [2:0]  seen;
  int          n;
  int          n_var;
  int          n_fix;
  int          cyc = 0;
  int          bad_count = 0;
  int          cmp_count = 0;
  // Row: write flag, index, write data, expected data, expected response
  logic [31:0] rows [NR] = '{32'h08a00000, 32'h08b00000, 32'h08c00000,
    32'h08d00000, 32'h18cff000, 32'h18b07000, 32'h18a00000,
    32'h140a5a50, 32'h1880f0f0, 32'h00000002, 32'h1f05a002};
  always #25 clk = ~clk;
  nsc_top #(.FIXED_CYCLES(FIX), .VAR_CYCLES(VAR)) u_nsc_top (
    .clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd_en),
    .avs_write(wr_en), .avs_writedata(wdat), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .avs_response(resp));
  nsc_host u_nsc_host (
    .clk(clk), .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en),
    .avs_writedata(wdat), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .avs_response(resp));
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic chk_d(input logic [7:0] g, e, input string m);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_r(input logic [1:0] g, e, input string m);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    u_nsc_host.xfer(1'b0, a, 8'h00);
    q = u_nsc_host.last_data;
    rs = u_nsc_host.last_resp;
  endtask
  task automatic wr(input logic [7:0] a, d);
    u_nsc_host.xfer(1'b1, a, d);
  endtask
  // Reference checksum of a blank array, expected byte left out
  function automatic logic [7:0] crc_blank();
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 127; i++) begin
      c = ({c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00)) ^ 8'hff;
    end
    return c;
  endfunction
  // Start a memory operation, gather activity bits until idle
  task automatic op(input logic [7:0] ctl, output int cnt,
                    output logic [2:0] s);
    cnt = 0;
    s = 3'h0;
    wr(8'h89, ctl);
    do begin
      rd(8'h8b);
      s = s | q[2:0];
      cnt++;
    end while (q[2:0] !== 3'h0 && cnt < 100);
  endtask
  task automatic run_chk(input logic [7:0] exp_res);
    wr(8'h8a, 8'h01);
    rd(8'h8c);
    chk_d(q & 8'h01, 8'h01, "check busy");
    rd(8'h8b);
    chk_d(q & 8'h01, 8'h01, "read busy");
    n = 0;
    do begin
      rd(8'h8c);
      n++;
    end while (q[0] !== 1'b0 && n < 100);
    chk_d({7'h00, n > 35}, 8'h01, "busy span");
    chk_d(q, exp_res, "result flags");
    rd(8'h8d);
    chk_d(q, crc, "computed value");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    crc = crc_blank();
    for (int i = 0; i < NR; i++) begin
      if (rows[i][28]) wr(rows[i][27:20], rows[i][19:12]);
      rd(rows[i][27:20]);
      if (rows[i][1:0] == 2'b00)
        chk_d(q, rows[i][11:4], "row data");
      chk_r(rs, rows[i][1:0], "row resp");
    end
    run_chk({6'h00, crc == 8'hb8, 1'b0});
    wr(8'h88, 8'h0f);
    op(8'h02, n_var, seen);
    chk_d({5'h00, seen}, 8'h02, "erase");
    op(8'h0a, n_fix, seen);
    chk_d({5'h00, seen}, 8'h02, "fix erase");
    chk_d({7'h00, n_fix > n_var}, 8'h01, "fixed time");
    for (int i = 0; i < 8; i++)
      wr(8'(8'h40 + i), (i == 7) ? crc : 8'hff);
    op(8'h04, n, seen);
    chk_d({5'h00, seen}, 8'h06, "erase prog");
    op(8'h01, n, seen);
    chk_d({5'h00, seen}, 8'h04, "program");
    run_chk(8'h02);
    wr(8'h47, ~crc);
    op(8'h04, n, seen);
    run_chk(8'h00);
    wr(8'h8a, 8'h01);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h8c);
    chk_d(q, 8'h00, "reset result");
    rd(8'h8b);
    chk_d(q, 8'h00, "reset activity");
    wrap_up();
  end
endmodule
`default_nettype wire
